// file: core/srla_pkg.sv
/*
   constants for the serial rom autoload/access block: register map, field positions,
   reset values and clock divider counts.
   assumes a 200 MHz pclk and an apb master on the register side.
*/
// Behaviour
// RULE1: a 0 to 1 write of the start bit begins one access; command bit picks direction.
// RULE2: hardware clears the start bit when the access finishes.
// RULE3: error flag at bit 2 sets on a missing acknowledge, else stays zero.
// RULE4: completion flag at bit 3 reads one only after a successful autoload.
// RULE5: serial clock divides core clock by 4096, 2048, 1024 or 128 per field.
// RULE6: autoload runs when bit 6 is zero and is skipped when it is one; bit 6 resets to zero, so the autoload always starts.
// RULE7: fast bit set runs autoload 32 times faster; resets to one.
// RULE8: in-progress flag at bit 8 is one while autoload runs.
// RULE9: access uses the seven-bit word address at bits 15:9.
// RULE10: write cycles store the sixteen-bit data field at bits 31:16.
// RULE11: a read cycle places the fetched word into the data field.
// RULE12: two-wire link, device drives clock, missing byte acknowledge aborts and flags error.
package srla_pkg;
   localparam logic [11:0] CTRL_OFFSET = 12'h070;
   localparam logic [11:0] IRQ_STATUS_OFFSET = 12'h074;
   localparam logic [11:0] IRQ_MASK_OFFSET = 12'h078;
   localparam int START_BIT = 0;
   localparam int CMD_BIT = 1;
   localparam int ERR_BIT = 2;
   localparam int DONE_BIT = 3;
   localparam int DIV_LSB = 4;
   localparam int SKIP_BIT = 6;
   localparam int FAST_BIT = 7;
   localparam int BUSY_BIT = 8;
   localparam int ADDR_LSB = 9;
   localparam int DATA_LSB = 16;
   localparam logic [1:0] DIV_RESET = 2'h0;
   localparam logic FAST_RESET = 1'b1;
   // full serial clock periods in core cycles per divider code
   localparam int DIV_CODE0 = 4096;
   localparam int DIV_CODE1 = 2048;
   localparam int DIV_CODE2 = 1024;
   localparam int DIV_CODE3 = 128;
   localparam int FAST_FACTOR = 32;
   // interrupt bits: access done, access error, autoload done
   localparam int IRQ_ACC_BIT = 0;
   localparam int IRQ_ERR_BIT = 1;
   localparam int IRQ_LOAD_BIT = 2;
   localparam int IRQ_W = 3;
   localparam logic [6:0] DEV_ADDR = 7'h50;
   typedef enum logic [2:0] {OP_IDLE, OP_START, OP_BYTE, OP_ACK, OP_STOP} srla_bit_op_t;
endpackage

// file: core/srla_top.sv
/*
   serial rom autoload and single-word access controller with apb register slave.
   assumes a 16-bit-word two-wire eeprom at a fixed device address, pins open drain.
*/
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
module srla_top #(
   parameter int LOAD_WORDS = 128 // words read during autoload
) (
   input wire logic pclk, // core clock
   input wire logic presetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [11:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped address
   output logic irq, // level interrupt
   output logic load_we, // one-cycle pulse: autoloaded word valid
   output logic [6:0] load_addr, // autoloaded word address
   output logic [15:0] load_data, // autoloaded word
   output logic rom_scl_o, // scl output level, always 0
   output logic rom_scl_oe, // scl drive enable
   output logic rom_sda_o, // sda output level, always 0
   output logic rom_sda_oe, // sda drive enable
   input wire logic rom_scl_i, // scl pin
   input wire logic rom_sda_i // sda pin
);
   typedef enum logic [3:0] {S_IDLE, S_START, S_DEV, S_AHI, S_ALO, S_DHI, S_DLO, S_RSTART,
      S_RDEV, S_RHI, S_RLO, S_STOP} srla_state_t;

   logic start_reg, cmd_reg, err_reg, done_reg, skip_reg, fast_reg, busy_reg;
   logic [1:0] div_reg;
   logic [6:0] addr_reg;
   logic [15:0] data_reg;
   logic [2:0] irq_sts_reg, irq_msk_reg;
   logic loading_reg, pending_load_reg, fail_reg, access_reg;
   logic [6:0] load_ptr_reg;
   logic [7:0] hi_reg;
   srla_state_t st_reg;
   logic phy_valid, phy_read, phy_nack, phy_done, phy_ack, scl_oe_w, sda_oe_w;
   srla_pkg::srla_bit_op_t phy_op;
   logic [7:0] phy_data, phy_rd;
   logic [12:0] quarter;
   logic wr_en, rd_en, mapped;
   logic [6:0] cur_addr;
   logic finish, acc_evt, err_evt, load_evt;

   // quarter-bit count for the chosen divider, shortened for fast autoload
   function automatic logic [12:0] quarter_of(input logic [1:0] code, input logic fast);
      int d;
      d = (code == 2'h0) ? srla_pkg::DIV_CODE0 : (code == 2'h1) ? srla_pkg::DIV_CODE1 :
          (code == 2'h2) ? srla_pkg::DIV_CODE2 : srla_pkg::DIV_CODE3;
      if (fast) d = d / srla_pkg::FAST_FACTOR;
      return 13'(d / 4);
   endfunction

   assign quarter = quarter_of(div_reg, loading_reg && fast_reg); // [RULE5] [RULE7]
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && !penable && !pwrite;
   assign mapped = (paddr == srla_pkg::CTRL_OFFSET) || (paddr == srla_pkg::IRQ_STATUS_OFFSET)
                   || (paddr == srla_pkg::IRQ_MASK_OFFSET);
   assign cur_addr = loading_reg ? load_ptr_reg : addr_reg;
   assign finish = phy_done && st_reg == S_STOP;

   srla_twi_phy u_phy (
      .pclk(pclk),
      .presetn(presetn),
      .quarter(quarter),
      .cmd_valid(phy_valid),
      .cmd_op(phy_op),
      .cmd_read(phy_read),
      .cmd_nack(phy_nack),
      .cmd_data(phy_data),
      .cmd_done(phy_done),
      .rd_data(phy_rd),
      .ack_ok(phy_ack),
      .scl_oe(scl_oe_w),
      .sda_oe(sda_oe_w),
      .scl_in(rom_scl_i),
      .sda_in(rom_sda_i)
   );

   // phy request for each sequence state
   always_comb begin
      phy_op = srla_pkg::OP_BYTE;
      phy_read = 1'b0;
      phy_nack = 1'b0;
      phy_data = 8'h00;
      unique case (st_reg)
         S_START, S_RSTART: phy_op = srla_pkg::OP_START;
         S_STOP: phy_op = srla_pkg::OP_STOP;
         S_DEV: phy_data = {srla_pkg::DEV_ADDR, 1'b0};
         S_RDEV: phy_data = {srla_pkg::DEV_ADDR, 1'b1};
         S_AHI: phy_data = 8'h00;
         S_ALO: phy_data = {1'b0, cur_addr}; // [RULE9]
         S_DHI: phy_data = data_reg[15:8]; // [RULE10]
         S_DLO: phy_data = data_reg[7:0];
         S_RHI: phy_read = 1'b1;
         S_RLO: begin phy_read = 1'b1; phy_nack = 1'b1; end
         default: phy_op = srla_pkg::OP_IDLE;
      endcase
   end

   // sequence: address phase, then write data or repeated start and two read bytes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= S_IDLE;
         phy_valid <= 1'b0;
         fail_reg <= 1'b0;
      end else begin
         phy_valid <= 1'b0;
         if (st_reg == S_IDLE) begin
            if (pending_load_reg || (start_reg && !access_reg)) begin
               st_reg <= S_START;
               phy_valid <= 1'b1;
               fail_reg <= 1'b0;
            end
         end else if (phy_done) begin
            phy_valid <= st_reg != S_STOP;
            if (st_reg == S_STOP) st_reg <= S_IDLE;
            else if ((st_reg == S_DEV || st_reg == S_AHI || st_reg == S_ALO || st_reg == S_DHI
                      || st_reg == S_DLO || st_reg == S_RDEV) && !phy_ack) begin
               fail_reg <= 1'b1; // [RULE12] abort on missing acknowledge
               st_reg <= S_STOP;
            end else begin
               unique case (st_reg)
                  S_START: st_reg <= S_DEV;
                  S_DEV: st_reg <= S_AHI;
                  S_AHI: st_reg <= S_ALO;
                  S_ALO: st_reg <= (cmd_reg && !loading_reg) ? S_DHI : S_RSTART; // [RULE1]
                  S_DHI: st_reg <= S_DLO;
                  S_DLO: st_reg <= S_STOP;
                  S_RSTART: st_reg <= S_RDEV;
                  S_RDEV: st_reg <= S_RHI;
                  S_RHI: st_reg <= S_RLO;
                  default: st_reg <= S_STOP;
               endcase
            end
         end
      end
   end

   // autoload control: runs once after reset; the skip bit resets to zero, so a later one can only cut it short
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pending_load_reg <= 1'b1;
         loading_reg <= 1'b0;
         load_ptr_reg <= 7'h00;
         done_reg <= 1'b0;
         busy_reg <= 1'b0;
         load_evt <= 1'b0;
      end else begin
         load_evt <= 1'b0;
         if (pending_load_reg && skip_reg) pending_load_reg <= 1'b0; // [RULE6]
         else if (pending_load_reg && st_reg == S_IDLE) begin
            pending_load_reg <= 1'b0;
            loading_reg <= 1'b1;
            busy_reg <= 1'b1; // [RULE8]
         end else if (loading_reg && finish) begin
            if (fail_reg || load_ptr_reg == 7'(LOAD_WORDS - 1)) begin
               loading_reg <= 1'b0;
               busy_reg <= 1'b0; // [RULE8]
               done_reg <= !fail_reg; // [RULE4]
               load_evt <= 1'b1;
            end else begin
               load_ptr_reg <= load_ptr_reg + 7'h01;
               pending_load_reg <= 1'b1;
               loading_reg <= 1'b0;
            end
         end
      end
   end

   // autoloaded words go out as one-cycle strobes; high byte held apart so the data field is untouched
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         load_we <= 1'b0;
         load_addr <= 7'h00;
         load_data <= 16'h0000;
         hi_reg <= 8'h00;
      end else begin
         load_we <= 1'b0;
         if (phy_done && st_reg == S_RHI) hi_reg <= phy_rd;
         if (loading_reg && phy_done && st_reg == S_RLO) begin
            load_we <= 1'b1;
            load_addr <= load_ptr_reg;
            load_data <= {hi_reg, phy_rd};
         end
      end
   end

   // control/status register; hardware writes win over software on the same edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start_reg <= 1'b0;
         cmd_reg <= 1'b0;
         err_reg <= 1'b0;
         div_reg <= srla_pkg::DIV_RESET;
         skip_reg <= 1'b0;
         fast_reg <= srla_pkg::FAST_RESET;
         addr_reg <= 7'h00;
         data_reg <= 16'h0000;
         access_reg <= 1'b0;
         acc_evt <= 1'b0;
         err_evt <= 1'b0;
      end else begin
         acc_evt <= 1'b0;
         err_evt <= 1'b0;
         if (wr_en && paddr == srla_pkg::CTRL_OFFSET) begin
            start_reg <= pwdata[srla_pkg::START_BIT] && !start_reg ? 1'b1 : start_reg; // [RULE1]
            cmd_reg <= pwdata[srla_pkg::CMD_BIT];
            div_reg <= pwdata[srla_pkg::DIV_LSB +: 2];
            skip_reg <= pwdata[srla_pkg::SKIP_BIT];
            fast_reg <= pwdata[srla_pkg::FAST_BIT];
            addr_reg <= pwdata[srla_pkg::ADDR_LSB +: 7];
            data_reg <= pwdata[srla_pkg::DATA_LSB +: 16];
         end
         if (st_reg == S_IDLE && start_reg && !pending_load_reg && !access_reg) begin
            access_reg <= 1'b1;
            err_reg <= 1'b0;
         end
         if (access_reg && phy_done && st_reg == S_RLO) data_reg <= {hi_reg, phy_rd}; // [RULE11]
         if (finish && loading_reg && fail_reg) err_reg <= 1'b1; // [RULE3]
         if (finish && access_reg) begin
            access_reg <= 1'b0;
            start_reg <= 1'b0; // [RULE2]
            err_reg <= fail_reg; // [RULE3]
            acc_evt <= 1'b1;
            err_evt <= fail_reg;
         end
      end
   end

   // sticky interrupt status, write one to clear; a new event beats the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_sts_reg <= 3'h0;
         irq_msk_reg <= 3'h0;
         irq <= 1'b0;
      end else begin
         if (wr_en && paddr == srla_pkg::IRQ_MASK_OFFSET) irq_msk_reg <= pwdata[2:0];
         irq_sts_reg <= (irq_sts_reg & ~((wr_en && paddr == srla_pkg::IRQ_STATUS_OFFSET) ?
            pwdata[2:0] : 3'h0)) | {load_evt, err_evt, acc_evt};
         irq <= |(irq_sts_reg & irq_msk_reg);
      end
   end

   // apb answer: two cycles, read data latched in setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
         if (rd_en) begin
            unique case (paddr)
               srla_pkg::CTRL_OFFSET: prdata <= {data_reg, addr_reg, busy_reg, fast_reg, skip_reg,
                  div_reg, done_reg, err_reg, cmd_reg, start_reg};
               srla_pkg::IRQ_STATUS_OFFSET: prdata <= {29'h0, irq_sts_reg};
               srla_pkg::IRQ_MASK_OFFSET: prdata <= {29'h0, irq_msk_reg};
               default: prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // open-drain pins: output level fixed low, enables registered in the phy
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rom_scl_o <= 1'b0;
         rom_sda_o <= 1'b0;
         rom_scl_oe <= 1'b0;
         rom_sda_oe <= 1'b0;
      end else begin
         rom_scl_o <= 1'b0;
         rom_sda_o <= 1'b0;
         rom_scl_oe <= scl_oe_w;
         rom_sda_oe <= sda_oe_w;
      end
   end
endmodule // srla_top

// file: core/srla_twi_phy.sv
/*
   two-wire byte engine: start, byte out with ack sample, byte in with master ack, stop.
   assumes sda/scl open drain with external pull-ups; inputs synchronised here.
*/
`timescale 1ns/1ps
module srla_twi_phy (
   input wire logic pclk, // core clock
   input wire logic presetn, // async reset, active low
   input wire logic [12:0] quarter, // core cycles per quarter serial bit
   input wire logic cmd_valid, // one-cycle request
   input wire srla_pkg::srla_bit_op_t cmd_op, // start, byte, stop
   input wire logic cmd_read, // byte is read, master drives ack bit
   input wire logic cmd_nack, // master sends nack after read byte
   input wire logic [7:0] cmd_data, // byte to send
   output logic cmd_done, // one-cycle completion
   output logic [7:0] rd_data, // byte received
   output logic ack_ok, // slave acknowledged last written byte
   output logic scl_oe, // pull scl low
   output logic sda_oe, // pull sda low
   input wire logic scl_in, // scl pin level
   input wire logic sda_in // sda pin level
);
   logic [1:0] sda_sync_reg;
   logic [1:0] scl_sync_reg;
   logic [12:0] tick_reg;
   logic [1:0] phase_reg;
   logic [3:0] bit_reg;
   logic [7:0] sh_reg;
   srla_pkg::srla_bit_op_t op_reg;
   logic rd_reg;
   logic nack_reg;
   logic step;

   // two-flop synchronisers; scl kept for completeness of pin sampling
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sda_sync_reg <= 2'h3;
         scl_sync_reg <= 2'h3;
      end else begin
         sda_sync_reg <= {sda_sync_reg[0], sda_in};
         scl_sync_reg <= {scl_sync_reg[0], scl_in};
      end
   end

   assign step = (tick_reg == 13'h0000) && (op_reg != srla_pkg::OP_IDLE);

   // quarter-bit timebase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) tick_reg <= 13'h0000;
      else if (cmd_valid || tick_reg == 13'h0000) tick_reg <= quarter - 13'h0001;
      else tick_reg <= tick_reg - 13'h0001;
   end

   // bit sequencer: each bit is four quarters, scl high in quarters 1 and 2
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         op_reg <= srla_pkg::OP_IDLE;
         phase_reg <= 2'h0;
         bit_reg <= 4'h0;
         sh_reg <= 8'h00;
         rd_reg <= 1'b0;
         nack_reg <= 1'b0;
         cmd_done <= 1'b0;
         rd_data <= 8'h00;
         ack_ok <= 1'b0;
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
      end else begin
         cmd_done <= 1'b0;
         if (cmd_valid) begin
            op_reg <= cmd_op;
            phase_reg <= 2'h0;
            bit_reg <= 4'h0;
            sh_reg <= cmd_read ? 8'hFF : cmd_data;
            rd_reg <= cmd_read;
            nack_reg <= cmd_nack;
         end else if (step) begin
            phase_reg <= phase_reg + 2'h1;
            unique case (op_reg)
               srla_pkg::OP_START: begin
                  // sda falls while scl high, then scl falls
                  unique case (phase_reg)
                     2'h0: begin sda_oe <= 1'b0; scl_oe <= 1'b0; end
                     2'h1: sda_oe <= 1'b1;
                     2'h2: scl_oe <= 1'b1;
                     2'h3: begin op_reg <= srla_pkg::OP_IDLE; cmd_done <= 1'b1; end
                  endcase
               end
               srla_pkg::OP_STOP: begin
                  unique case (phase_reg)
                     2'h0: begin sda_oe <= 1'b1; scl_oe <= 1'b1; end
                     2'h1: scl_oe <= 1'b0;
                     2'h2: sda_oe <= 1'b0;
                     2'h3: begin op_reg <= srla_pkg::OP_IDLE; cmd_done <= 1'b1; end
                  endcase
               end
               default: begin
                  // nine bits: eight data then the acknowledge slot
                  unique case (phase_reg)
                     2'h0: begin
                        scl_oe <= 1'b1;
                        if (bit_reg == 4'h8) sda_oe <= rd_reg ? !nack_reg : 1'b0;
                        else sda_oe <= rd_reg ? 1'b0 : !sh_reg[7];
                     end
                     2'h1: scl_oe <= 1'b0;
                     2'h2: begin
                        if (bit_reg == 4'h8) ack_ok <= rd_reg || !sda_sync_reg[1]; // [RULE12]
                        else sh_reg <= {sh_reg[6:0], sda_sync_reg[1]};
                     end
                     2'h3: begin
                        scl_oe <= 1'b1;
                        bit_reg <= bit_reg + 4'h1;
                        if (bit_reg == 4'h8) begin
                           op_reg <= srla_pkg::OP_IDLE;
                           cmd_done <= 1'b1;
                           rd_data <= sh_reg;
                        end
                     end
                  endcase
               end
            endcase
         end
      end
   end
endmodule // srla_twi_phy

// file: dv/serial_rom_autoload_access_bench.sv
/*
   bench for srla_top: apb tasks, rom model on the wired pins.
   assumes the checker binds itself.
*/
`timescale 1ns/1ps
module serial_rom_autoload_access_bench;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, refuse = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, q, prdata;
   logic pready, pslverr, irq, load_we, scl_oe, sda_oe, scl_o, sda_o, pull, err;
   logic [6:0] load_addr;
   logic [15:0] load_data;
   logic [6:0] ra [3] = '{7'h05, 7'h03, 7'h7F};
   wire scl = scl_oe ? scl_o : 1'b1; // pull-up on the clock line
   wire sda = (sda_oe || pull) ? 1'b0 : 1'b1; // wired-and with pull-up
   int num_errors = 0, n_checks = 0, nloads = 0;
   always #2.5 pclk = ~pclk;
   srla_top #(.LOAD_WORDS(2)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irq(irq), .load_we(load_we), .load_addr(load_addr), .load_data(load_data), .rom_scl_o(scl_o),
      .rom_scl_oe(scl_oe), .rom_sda_o(sda_o), .rom_sda_oe(sda_oe), .rom_scl_i(scl), .rom_sda_i(sda));
   srla_rom_model rom (.scl(scl), .sda(sda), .refuse(refuse), .sda_pull(pull));
   function automatic logic [15:0] pat(input logic [6:0] a);
      return {1'b0, a, 1'b1, a};
   endfunction
   // ctrl word: fast, no skip, divider 128; done reads !go
   function automatic logic [31:0] ctl(input logic [15:0] d, input logic [6:0] a, input logic cmd, go, e);
      return {d, a, 3'b010, 2'h3, !go, e, cmd, go};
   endfunction
   task automatic give_verdict;
      if (num_errors == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask
   // one apb transfer; request held until ready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         num_errors++;
         give_verdict();
      end
   endtask
   // poll the control register until bit b reads zero; bounded
   task automatic wait_clear(input int b);
      int n = 0;
      do begin
         apb(1'b0, 12'h070, 32'h0);
         n++;
      end while (q[b] !== 1'b0 && n < 20000);
      if (n >= 20000) begin
         num_errors++;
         give_verdict();
      end
   endtask
   task automatic irq_is(input logic v);
      repeat (2) @(posedge pclk); // interrupt output lags status by one cycle
      chk({31'h0, irq}, {31'h0, v}, "irq level");
   endtask
   // every autoloaded word must come out in address order with the rom content
   always @(posedge pclk) if (load_we === 1'b1) begin
      chk({25'h0, load_addr}, 32'(nloads), "load address");
      chk({16'h0, load_data}, {16'h0, pat(7'(nloads))}, "load data");
      nloads++;
   end
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      apb(1'b0, 12'h070, 32'h0);
      chk(q & 32'h0000_01FF, 32'h0000_0180, "ctrl after reset");
      wait_clear(srla_pkg::BUSY_BIT);
      chk(q, 32'h0000_0088, "ctrl after autoload");
      chk(32'(nloads), 32'h2, "autoload count");
      apb(1'b0, 12'h074, 32'h0);
      chk(q, 32'h0000_0004, "load event");
      irq_is(1'b0);
      apb(1'b1, 12'h078, 32'h0000_0007);
      irq_is(1'b1);
      apb(1'b1, 12'h074, 32'h0000_0007);
      irq_is(1'b0);
      // write one word, read it and two others
      apb(1'b1, 12'h070, ctl(16'hBEEF, 7'h05, 1'b1, 1'b1, 1'b0));
      wait_clear(0);
      chk(q, ctl(16'hBEEF, 7'h05, 1'b1, 1'b0, 1'b0), "write cycle");
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, 12'h070, ctl(16'h0, ra[i], 1'b0, 1'b1, 1'b0));
         wait_clear(0);
         chk(q, ctl((i == 0) ? 16'hBEEF : pat(ra[i]), ra[i], 1'b0, 1'b0, 1'b0), "read cycle");
      end
      // refused acks: abort, error flag and event, no write
      refuse <= 1'b1;
      apb(1'b1, 12'h070, ctl(16'h1234, 7'h07, 1'b1, 1'b1, 1'b0));
      wait_clear(0);
      chk(q, ctl(16'h1234, 7'h07, 1'b1, 1'b0, 1'b1), "missing ack");
      apb(1'b0, 12'h074, 32'h0);
      chk(q & 32'h0000_0002, 32'h0000_0002, "error event");
      irq_is(1'b1);
      apb(1'b1, 12'h074, 32'h0000_0007);
      irq_is(1'b0);
      refuse <= 1'b0;
      apb(1'b1, 12'h070, ctl(16'h0, 7'h07, 1'b0, 1'b1, 1'b0));
      wait_clear(0);
      chk(q, ctl(pat(7'h07), 7'h07, 1'b0, 1'b0, 1'b0), "read after abort");
      apb(1'b0, 12'h07C, 32'h0);
      chk(q, 32'h0, "unmapped read data");
      chk({31'h0, err}, 32'h1, "unmapped refused");
      // field readback; read-only bits ignore writes
      for (int c = 0; c < 4; c++) begin
         apb(1'b1, 12'h070, {23'h0, 1'b1, c[0], 1'b1, 2'(c), 4'hC});
         apb(1'b0, 12'h070, 32'h0);
         chk(q, {23'h0, 1'b0, c[0], 1'b1, 2'(c), 4'h8}, "field readback");
      end
      give_verdict();
   end
endmodule // serial_rom_autoload_access_bench

// file: dv/srla_rom_model.sv
/*
   two-wire serial rom model: 128 words of 16 bits.
   assumes pulled-up lines; pulls data low only, never stretches the clock.
*/
`timescale 1ns/1ps
module srla_rom_model (
   input wire logic scl, // wired clock line
   input wire logic sda, // wired data line
   input wire logic refuse, // withhold every acknowledge
   output logic sda_pull // high while the model pulls data low
);
   logic [15:0] mem [0:127];
   logic [15:0] wd;
   logic [7:0] sh;
   logic [6:0] wa;
   logic rd, go_rd, quit;
   int bitn, nb;
   // word i holds a pattern the bench can rebuild from i
   initial begin
      for (int i = 0; i < 128; i++) mem[i] = {1'b0, 7'(i), 1'b1, 7'(i)};
      sda_pull = 1'b0;
      quit = 1'b1;
   end
   // start or repeated start: the next clock fall opens bit 0
   always @(negedge sda) if (scl === 1'b1) begin
      bitn = -1;
      nb = 0;
      rd = 1'b0;
      go_rd = 1'b0;
      quit = 1'b0;
      sda_pull = 1'b0;
   end
   // stop: let go of the line until the next start
   always @(posedge sda) if (scl === 1'b1) quit = 1'b1;
   // sample address and data bits, or the master's acknowledge while reading
   always @(posedge scl) if (!quit) begin
      if (!rd && bitn >= 0 && bitn < 8) sh = {sh[6:0], sda};
      if (rd && bitn == 8 && sda === 1'b1) quit = 1'b1;
   end
   // data changes only while the clock is low
   always @(negedge scl) begin
      sda_pull = 1'b0;
      if (!quit) begin
         bitn = (bitn == 8) ? 0 : bitn + 1;
         if (!rd && bitn == 8) begin
            if (nb == 0) go_rd = sh[0];
            if (nb == 2) wa = sh[6:0];
            if (nb == 3) wd[15:8] = sh;
            if (nb == 4) mem[wa] = {wd[15:8], sh};
            nb++;
            sda_pull = !refuse;
         end
         if (go_rd && bitn == 0) begin
            rd = 1'b1;
            go_rd = 1'b0;
            wd = mem[wa];
         end
         if (rd && bitn < 8) begin
            sda_pull = !wd[15];
            wd = {wd[14:0], 1'b0};
         end
      end
   end
endmodule // srla_rom_model

// file: dv/srla_top_asserts.sv
/*
   port-level checks on srla_top, bound at the foot of this file.
   assumes one clock domain.
*/
`timescale 1ns/1ps
module srla_top_asserts #(
   parameter int LOAD_WORDS = 128 // autoload length
) (
   input wire logic pclk, // core clock
   input wire logic presetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [11:0] paddr, // apb address
   input wire logic [31:0] pwdata, // apb write data
   input wire logic [31:0] prdata, // apb read data
   input wire logic pready, // apb ready
   input wire logic pslverr, // apb error
   input wire logic irq, // interrupt
   input wire logic load_we, // autoload strobe
   input wire logic [6:0] load_addr, // autoload address
   input wire logic [15:0] load_data, // autoload word
   input wire logic rom_scl_o, // scl level
   input wire logic rom_scl_oe, // scl enable
   input wire logic rom_sda_o, // sda level
   input wire logic rom_sda_oe, // sda enable
   input wire logic rom_scl_i, // scl pin
   input wire logic rom_sda_i // sda pin
);
   // half a bit at divider 128
   localparam int MIN_GAP = 64;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic scl_q;
   logic [8:0] gap;
   wire scl_rise = rom_scl_oe & ~scl_q;
   // cycles since the clock line was last pulled low, saturating
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_q <= 1'b0;
         gap <= 9'h1FF;
      end else begin
         scl_q <= rom_scl_oe;
         gap <= scl_rise ? 9'h001 : ((gap == 9'h1FF) ? gap : gap + 9'h001);
      end
   end
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence kick_s;
      pready && psel && penable && pwrite && paddr == 12'h070 && pwdata[0] && pwdata[5:4] == 2'h3;
   endsequence
   a_pready_answer: assert property (setup_s |=> pready) else $error("no ready in access cycle");
   a_pready_phase: assert property (pready |-> psel && penable) else $error("ready outside access");
   a_slverr_unmapped: assert property (setup_s ##0 (paddr != 12'h070 && paddr != 12'h074 && paddr != 12'h078)
      |=> pslverr) else $error("unmapped access not refused");
   a_open_drain: assert property (!rom_scl_o && !rom_sda_o) else $error("pin driven high");
   a_start_kick: assert property (kick_s ##0 (!rom_scl_oe && !rom_sda_oe) |-> ##[1:1000] rom_sda_oe)
      else $error("start bit did not begin a cycle");
   a_scl_gap: assert property (scl_rise |-> gap >= MIN_GAP) else $error("serial clock too fast");
   a_load_pulse: assert property (load_we |-> load_addr < LOAD_WORDS ##1 !load_we)
      else $error("bad autoload strobe");
   a_done_not_busy: assert property ($past(psel && !penable && !pwrite && paddr == 12'h070) && pready
      |-> !(prdata[srla_pkg::DONE_BIT] && prdata[srla_pkg::BUSY_BIT])) else $error("done while busy");
endmodule // srla_top_asserts

bind srla_top srla_top_asserts #(.LOAD_WORDS(LOAD_WORDS)) u_asserts (.*);
